// *** sim/spiec_slave_model.sv ***
// External serial slave that answers the master port
`timescale 1ns/1ps
module spiec_slave_model (
  input wire logic sclk,
  input wire logic selN,
  input wire logic mosi,
  input wire logic [31:0] txWord,
  output logic miso,
  output logic [31:0] rxWord
);
  logic [31:0] outBits; // Reply bits still to send, MSB first
  initial begin
    miso = 1'h0;
    rxWord = 32'h0000_0000;
    outBits = 32'h0000_0000;
  end
  // Fresh reply word at every selection
  always @(negedge selN) begin
    outBits = txWord;
  end
  // Phase 1: launch on rising, master samples on falling
  always @(posedge sclk) begin
    if (!selN) begin
      miso = outBits[31];
      outBits = outBits << 1;
    end
  end
  // Capture the master's bits at its sampling edge
  always @(negedge sclk) begin
    if (!selN) begin
      rxWord = {rxWord[30:0], mosi};
    end
  end
  // Released line must not keep showing the last bit
  always @(posedge selN) begin
    miso = ~miso;
  end
endmodule : spiec_slave_model

// *** sim/spiec_top_tb.sv ***
// Self-checking bench for the port error and DMA control block
`timescale 1ns/1ps
`include "spiec_regs.svh"
module spiec_top_tb import spiec_pkg::*;;
  logic clk = 1'h0; // 125 MHz
  logic rstn, awvalid, wvalid, arvalid, bready, rready;
  logic [7:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic sclkIn, mosiIn, misoIn, devSelInN, dmaTxWe, dmaRxAck, dmaFifoFull;
  logic awready, wready, bvalid, arready, rvalid, sclkPrev;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] wdata, dmaTxData, rdata, dmaRxData, partTx, partRx, v;
  logic sclkOut, sclkOe, mosiOut, mosiOe, misoOut, misoOe, ssOutN, ssOe;
  logic dmaTxReq, dmaRxReq, dmaDone, chainStart, portIrq;
  int badCount = 0;
  int testsRun = 0;
  int edges = 0, gap = 0, halfLen = 0, chains = 0, dones = 0, cycles = 0;
  int e0;
  spiec_top dut (.clk, .rstn, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .sclkIn,
    .sclkOut, .sclkOe, .mosiIn, .mosiOut, .mosiOe, .misoIn, .misoOut,
    .misoOe, .devSelInN, .ssOutN, .ssOe, .dmaTxReq, .dmaTxWe, .dmaTxData,
    .dmaRxReq, .dmaRxData, .dmaRxAck, .dmaFifoFull, .dmaDone, .chainStart,
    .portIrq);
  // Far side sees idle low clock and pulled-up data when not driven
  spiec_slave_model part (.sclk(sclkOe ? sclkOut : 1'h0),
    .selN(ssOe ? ssOutN : 1'h1), .mosi(mosiOe ? mosiOut : 1'h1),
    .txWord(partTx), .miso(misoIn), .rxWord(partRx));
  always #4 clk = ~clk;
  // Clock edge spacing, pulse counts and the hang limit
  always @(posedge clk) begin
    sclkPrev <= sclkOut;
    gap <= (sclkOut !== sclkPrev) ? 1 : gap + 1;
    if (sclkOut !== sclkPrev) begin
      edges <= edges + 1;
      halfLen <= gap;
    end
    if (chainStart === 1'h1) chains <= chains + 1;
    if (dmaDone === 1'h1) dones <= dones + 1;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      badCount++;
      testDone();
    end
  end
  task automatic testDone;
    if (badCount == 0 && testsRun > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : testDone
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Registered readies: the value at the falling edge is the sampled one
  task automatic axiW(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    b = 1'h0;
    while (!b) begin
      @(negedge clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid && bready;
      resp = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
    end
  endtask : axiW
  task automatic axiR(input logic [7:0] a, output logic [31:0] d);
    logic ar, r;
    araddr <= a;
    arvalid <= 1'h1;
    r = 1'h0;
    while (!r) begin
      @(negedge clk);
      ar = arvalid && arready;
      r = rvalid && rready;
      d = rdata;
      resp = rresp;
      @(posedge clk);
      if (ar) arvalid <= 1'h0;
    end
  endtask : axiR
  task automatic rdChk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    logic [31:0] d;
    axiR(a, d);
    chk($sformatf("reg %h", a), e, d & m);
  endtask : rdChk
  // Poll until a word has landed in the receive buffer
  task automatic waitRx;
    v = 32'h0000_0000;
    for (int i = 0; i < 400 && v[`FB_RXS] !== 1'h1; i++) axiR(`OFS_FLAG, v);
    chk("rx full", 32'h1, {31'h0, v[`FB_RXS]});
  endtask : waitRx
  // Bench as external master, phase 1, link clock of 125 ns
  task automatic slvWord(input logic [31:0] w);
    devSelInN <= 1'h0;
    #100;
    for (int i = 31; i >= 0; i--) begin
      sclkIn = 1'h1;
      mosiIn = w[i];
      #62.5;
      sclkIn = 1'h0;
      #62.5;
    end
    #100;
    devSelInN <= 1'h1;
    mosiIn <= ~mosiIn;
    #200;
    @(posedge clk);
  endtask : slvWord
  initial begin
    {rstn, awvalid, wvalid, arvalid, sclkIn, mosiIn} = 6'h00;
    {dmaTxWe, dmaRxAck, dmaFifoFull} = 3'h0;
    {bready, rready, devSelInN} = 3'h7;
    {awaddr, araddr, wstrb} = 20'h0_000F;
    {wdata, dmaTxData} = 64'h0000_0000_0000_0000;
    partTx = 32'hA5C3_0F96;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    // Reset values, unmapped read, select pin level
    rdChk(`OFS_CTRL, 32'hFFFF_FFFF, `ZERO32);
    rdChk(`OFS_BAUD, 32'hFFFF_FFFF, 32'h0000_0001);
    rdChk(`OFS_DMAC, 32'hFFFF_FFFF, `ZERO32);
    axiR(8'h2C, v);
    chk("unmapped resp", {30'h0, `RESP_ERR}, {30'h0, resp});
    rdChk(`OFS_FLAG, 32'hFFFF_FFFF, 32'h0000_0080);
    devSelInN <= 1'h0;
    repeat (4) @(posedge clk);
    rdChk(`OFS_FLAG, 32'h0000_0080, `ZERO32);
    devSelInN <= 1'h1;
    // Master, mode 01: divisor 2, word exchange, stall on empty
    axiW(`OFS_BAUD, 32'h0000_0002);
    axiW(`OFS_CTRL, 32'h0000_000F);
    axiW(`OFS_TX, 32'h3C5A_9617);
    waitRx();
    chk("half period", 32'h0000_0008, halfLen);
    chk("far side word", 32'h3C5A_9617, partRx);
    rdChk(`OFS_RX, 32'hFFFF_FFFF, 32'hA5C3_0F96);
    rdChk(`OFS_FLAG, 32'h0000_0001, `ZERO32);
    e0 = edges;
    repeat (150) @(posedge clk);
    chk("stalled edges", e0, edges);
    axiW(`OFS_TX, 32'h0000_0001);
    waitRx();
    chk("resumed", 32'h1, {31'h0, edges != e0});
    axiR(`OFS_RX, v);
    // Mode 00 with send-zeros: underrun, stall on full receive
    axiW(`OFS_CTRL, `ZERO32);
    axiW(`OFS_CTRL, 32'h0000_0027);
    waitRx();
    chk("zeros sent", `ZERO32, partRx);
    rdChk(`OFS_STAT, 32'hFFFF_FFFF, 32'h0000_0004);
    e0 = edges;
    repeat (150) @(posedge clk);
    chk("stalled edges", e0, edges);
    axiW(`OFS_STAT, 32'h0000_0004);
    rdChk(`OFS_STAT, 32'hFFFF_FFFF, `ZERO32);
    axiR(`OFS_RX, v);
    repeat (30) @(posedge clk);
    chk("resumed", 32'h1, {31'h0, edges != e0});
    axiW(`OFS_CTRL, `ZERO32);
    axiW(`OFS_STAT, 32'h0000_00FF);
    axiR(`OFS_RX, v);
    // Fault while enabled master, refused re-enable, clearing
    axiW(`OFS_CTRL, 32'h0000_000F);
    devSelInN <= 1'h0;
    repeat (6) @(negedge clk);
    chk("irq", 32'h1, {31'h0, portIrq});
    chk("drivers", `ZERO32, {29'h0, sclkOe, mosiOe, misoOe});
    @(posedge clk);
    rdChk(`OFS_STAT, 32'h0000_0002, 32'h0000_0002);
    rdChk(`OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_000C);
    devSelInN <= 1'h1;
    axiW(`OFS_CTRL, 32'h0000_000F);
    rdChk(`OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_000C);
    axiW(`OFS_STAT, 32'h0000_0002);
    repeat (2) @(negedge clk);
    chk("irq", `ZERO32, {31'h0, portIrq});
    @(posedge clk);
    // Slave overrun: keep old word, then overwrite with get-more
    axiW(`OFS_CTRL, 32'h0000_0005);
    slvWord(32'h1111_2222);
    slvWord(32'h3333_4444);
    rdChk(`OFS_STAT, 32'h0000_0010, 32'h0000_0010);
    rdChk(`OFS_RX, 32'hFFFF_FFFF, 32'h1111_2222);
    axiW(`OFS_STAT, 32'h0000_00FF);
    axiW(`OFS_CTRL, 32'h0000_0045);
    slvWord(32'h5555_6666);
    slvWord(32'h7777_8888);
    rdChk(`OFS_RX, 32'hFFFF_FFFF, 32'h7777_8888);
    rdChk(`OFS_STAT, 32'h0000_0010, 32'h0000_0010);
    axiW(`OFS_CTRL, `ZERO32);
    axiW(`OFS_STAT, 32'h0000_00FF);
    // Chain start refused until port and DMA are enabled
    axiW(`OFS_DMAC, 32'h0000_0004);
    axiW(`OFS_CNT, 32'h0000_0002);
    axiW(`OFS_IDX, 32'h0000_0040);
    axiW(`OFS_MOD, 32'h0000_0001);
    axiW(`OFS_CP, 32'h0000_0100);
    repeat (4) @(posedge clk);
    chk("chain starts", `ZERO32, chains);
    axiW(`OFS_CTRL, 32'h0000_0005);
    axiW(`OFS_DMAC, 32'h0000_0005);
    axiW(`OFS_CP, 32'h0000_0200);
    repeat (4) @(posedge clk);
    chk("chain starts", 32'h0000_0001, chains);
    axiW(`OFS_DMAC, `ZERO32);
    axiW(`OFS_CTRL, `ZERO32);
    // Master transmit DMA of one word
    axiW(`OFS_CTRL, 32'h0000_000F);
    axiW(`OFS_CNT, 32'h0000_0001);
    axiW(`OFS_DMAC, 32'h0000_0001);
    for (int i = 0; i < 50 && dmaTxReq !== 1'h1; i++) @(negedge clk);
    chk("tx request", 32'h1, {31'h0, dmaTxReq});
    @(posedge clk);
    dmaTxWe <= 1'h1;
    dmaTxData <= 32'h5AA5_0FF0;
    @(posedge clk);
    dmaTxWe <= 1'h0;
    repeat (3) @(negedge clk);
    chk("tx request", `ZERO32, {31'h0, dmaTxReq});
    chk("done pulses", 32'h0000_0001, dones);
    repeat (700) @(posedge clk);
    chk("far side word", 32'h5AA5_0FF0, partRx);
    // Master receive DMA: clock runs until FIFO and buffer are full
    axiW(`OFS_CTRL, 32'h0000_0007);
    axiW(`OFS_CNT, 32'h0000_0002);
    axiW(`OFS_DMAC, 32'h0000_0003);
    for (int i = 0; i < 900 && dmaRxReq !== 1'h1; i++) @(negedge clk);
    chk("dma rx word", 32'hA5C3_0F96, dmaRxData);
    @(posedge clk);
    dmaFifoFull <= 1'h1;
    dmaRxAck <= 1'h1;
    @(posedge clk);
    dmaRxAck <= 1'h0;
    repeat (1200) @(posedge clk);
    chk("rx request", 32'h1, {31'h0, dmaRxReq});
    e0 = edges;
    repeat (150) @(posedge clk);
    chk("stalled edges", e0, edges);
    testDone();
  end
endmodule : spiec_top_tb

// *** src/spiec_pkg.sv ***
// Types shared by the port error and DMA control block
package spiec_pkg;
  // Serial engine state, one-hot
  typedef enum logic [2:0] {
    SPIEC_IDLE = 3'b001,
    SPIEC_RUN = 3'b010,
    SPIEC_HOLD = 3'b100
  } spiec_eng_t;
endpackage : spiec_pkg

// *** src/spiec_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef SPIEC_REGS_SVH
`define SPIEC_REGS_SVH
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h04
`define OFS_FLAG 8'h08
`define OFS_BAUD 8'h0C
`define OFS_DMAC 8'h10
`define OFS_CNT 8'h14
`define OFS_IDX 8'h18
`define OFS_MOD 8'h1C
`define OFS_CP 8'h20
`define OFS_TX 8'h24
`define OFS_RX 8'h28
`define OFS_LAST 8'h28
// Port control fields
`define CB_EN 0
`define CB_MS 1
`define CB_CPH 2
`define CB_TIM 3
`define CB_SZ 5
`define CB_GM 6
// Error status fields, write one to clear
`define SB_MME 1
`define SB_UNF 2
`define SB_OVF 4
`define SB_COL 6
// Flag status fields
`define FB_RXS 0
`define FB_TXS 1
`define FB_DS 7
// DMA control fields
`define DB_EN 0
`define DB_RX 1
`define DB_CH 2
`define DB_IE 3
`define DB_MME 12
`define DB_UNF 13
`define DB_OVF 14
`define DB_ERR 15
// Initiation modes
`define TIM_RX 2'b00
`define TIM_TX 2'b01
// Reset values
`define ZERO32 32'h0000_0000
`define BAUD_RST 15'h0001
// Widths and timing
`define WORD_BITS 32
`define BAUD_W 15
`define BAUD_DIV 8
`define RXS_LAT 4
`define SYNC_LAT 2
// Bus answers
`define RESP_OK 2'b00
`define RESP_ERR 2'b10
`endif

// *** src/spiec_top.sv ***
// Serial port with error flags, baud divider, buffers and DMA control
`timescale 1ns/1ps
`include "spiec_regs.svh"
module spiec_top import spiec_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic sclkIn,
  output logic sclkOut,
  output logic sclkOe,
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  input wire logic devSelInN,
  output logic ssOutN,
  output logic ssOe,
  output logic dmaTxReq,
  input wire logic dmaTxWe,
  input wire logic [31:0] dmaTxData,
  output logic dmaRxReq,
  output logic [31:0] dmaRxData,
  input wire logic dmaRxAck,
  input wire logic dmaFifoFull,
  output logic dmaDone,
  output logic chainStart,
  output logic portIrq
);
  localparam int WB = `WORD_BITS;

  // Byte-lane merge of a bus write into a register
  function automatic logic [31:0] wmerge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // Offset decode shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `OFS_LAST);
  endfunction : mapped

  // Control state
  logic portEn_reg, msSel_reg, cph_reg, sz_reg, gm_reg; // Port control
  logic [1:0] tim_reg; // Initiation mode
  logic [`BAUD_W-1:0] baud_reg; // Divisor field
  logic mme_reg, transmit_underrun_flag_reg, receive_overrun_flag_reg, transmit_collision_flag_reg; // Sticky errors
  logic dmaEn_reg, dmaRx_reg, chEn_reg, dmaIe_reg; // DMA control
  logic dMme_reg, dUnf_reg, dOvf_reg; // DMA-time errors
  logic [15:0] cnt_reg; // DMA word count
  logic [31:0] idx_reg, mod_reg, cp_reg; // DMA parameters
  logic [2:0] pSeen_reg; // Which parameters were written
  logic [31:0] txBuf_reg, rxBuf_reg; // Data buffers
  logic txs_reg, rxs_reg; // Buffer full status
  // Synchronisers: sclk, select, mosi, miso
  logic [3:0] syncA_reg, syncB_reg;
  logic sclkD_reg; // Previous synced clock, for edges
  // Serial engine
  spiec_eng_t eng_reg, eng_next;
  logic [5:0] bitCnt_reg;
  logic [WB-1:0] txShift_reg, rxShift_reg;
  logic [16:0] divCnt_reg;
  logic [2:0] done_reg; // Completion delay line
  // Bus slave state
  logic awHeld_reg, wHeld_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;

  // Synced pins; only second stage is read
  wire sclkS = syncB_reg[3];
  wire dsS = syncB_reg[2];
  wire mosiS = syncB_reg[1];
  wire misoS = syncB_reg[0];

  // Bus handshakes
  wire awTake = awvalid & awready;
  wire wTake = wvalid & wready;
  wire arTake = arvalid & arready;
  wire doWr = awHeld_reg & wHeld_reg & ~bvalid;
  wire wrOk = doWr & mapped(awAddr_reg);
  wire wrCtrl = wrOk & (awAddr_reg == `OFS_CTRL);
  wire wrStat = wrOk & (awAddr_reg == `OFS_STAT) & wStrb_reg[0];
  wire wrBaud = wrOk & (awAddr_reg == `OFS_BAUD);
  wire wrDmac = wrOk & (awAddr_reg == `OFS_DMAC);
  wire wrCnt = wrOk & (awAddr_reg == `OFS_CNT);
  wire wrIdx = wrOk & (awAddr_reg == `OFS_IDX);
  wire wrMod = wrOk & (awAddr_reg == `OFS_MOD);
  wire wrCp = wrOk & (awAddr_reg == `OFS_CP);
  wire swTxWr = wrOk & (awAddr_reg == `OFS_TX);
  wire [31:0] wm = wmerge(`ZERO32, wData_reg, wStrb_reg);
  wire [31:0] ctrlM = wmerge({25'h0, gm_reg, sz_reg, tim_reg, cph_reg,
      msSel_reg, portEn_reg}, wData_reg, wStrb_reg);
  wire [31:0] dmacM = wmerge({28'h0, dmaIe_reg, chEn_reg, dmaRx_reg,
      dmaEn_reg}, wData_reg, wStrb_reg);
  // Divisor merge; only the low field is kept
  wire [31:0] baudM = wmerge({17'h0, baud_reg}, wData_reg, wStrb_reg);
  wire [3:0] w1c = {wData_reg[`SB_COL], wData_reg[`SB_OVF],
      wData_reg[`SB_UNF], wData_reg[`SB_MME]} & {4{wrStat}};
  wire rxRead = (arTake & (araddr == `OFS_RX)) | dmaRxAck;

  // Mode decode
  wire isMaster = portEn_reg & msSel_reg;
  wire selected = portEn_reg & ~msSel_reg & ~dsS;
  wire dmaTxMode = dmaEn_reg & ~dmaRx_reg;
  wire dmaRxMode = dmaEn_reg & dmaRx_reg;
  wire active = (eng_reg == SPIEC_RUN);
  wire mmeEv = isMaster & ~dsS;
  // A finished word still on its way to the buffer counts as full,
  // otherwise the next word would start inside the completion latency
  wire rxPend = rxs_reg | (|done_reg);
  // Master clock stall decode
  wire stall = dmaRxMode ? (rxPend & dmaFifoFull) :
      dmaTxMode ? ~txs_reg :
      (tim_reg == `TIM_TX) ? ~txs_reg :
      rxPend;
  // Half period is four times the divisor, giving clk/(8*N)
  wire [16:0] halfDiv = 17'({2'b00, baud_reg} * 17'(`BAUD_DIV / 2));
  wire tick = isMaster & active &
      (divCnt_reg == halfDiv - 17'h1);
  wire sRise = sclkS & ~sclkD_reg;
  wire sFall = ~sclkS & sclkD_reg;
  wire lead = isMaster ? (tick & ~sclkOut) : (sRise & selected);
  wire trail = isMaster ? (tick & sclkOut) : (sFall & selected);
  wire sampleEv = active & (cph_reg ? trail : lead);
  wire shiftEv = active &
      (cph_reg ? (lead & (bitCnt_reg != 6'h0)) : trail);
  wire lastSample = sampleEv & (bitCnt_reg == 6'(WB - 1));
  wire wordEnd = (isMaster & ~cph_reg) ?
      (trail & (bitCnt_reg == 6'(WB))) : lastSample;
  // Baud zero is invalid and never starts a master word
  wire mstStart = (eng_reg == SPIEC_IDLE) & isMaster & ~stall &
      (baud_reg != 15'h0000);
  wire load = mstStart | ((eng_reg == SPIEC_IDLE) & selected);
  wire inBit = isMaster ? misoS : mosiS;
  // Empty buffer sends zeros or repeats the held word
  wire [WB-1:0] loadData = (txs_reg | ~sz_reg) ?
      txBuf_reg[WB-1:0] : {WB{1'b0}};
  wire txWrite = swTxWr | dmaTxWe;
  // Completion tap: synced slave path already spent two cycles
  wire rxEv = isMaster ? done_reg[`RXS_LAT-2] :
      done_reg[`RXS_LAT-`SYNC_LAT-2];
  wire unfEv = load & ~txs_reg & ~dmaRxMode;
  wire ovfEv = rxEv & rxs_reg & ~rxRead;
  wire colEv = txWrite & load & ~(~msSel_reg & ~cph_reg);
  wire dmaMove = (dmaTxWe | dmaRxAck) & (cnt_reg != 16'h0000);
  wire dErrs = dMme_reg | dUnf_reg | dOvf_reg;

  // Input synchronisers
  always_ff @(posedge clk) begin
    syncA_reg <= {sclkIn, devSelInN, mosiIn, misoIn};
    syncB_reg <= syncA_reg;
    sclkD_reg <= syncB_reg[3];
  end

  // Engine next state
  always_comb begin
    eng_next = eng_reg;
    unique case (eng_reg)
      SPIEC_IDLE: begin
        if (load) begin
          eng_next = SPIEC_RUN;
        end
      end
      SPIEC_RUN: begin
        // Deselect or disable aborts the word
        if (~portEn_reg | (~msSel_reg & dsS)) begin
          eng_next = SPIEC_IDLE;
        end else if (wordEnd) begin
          eng_next = SPIEC_HOLD;
        end
      end
      SPIEC_HOLD: begin
        eng_next = SPIEC_IDLE;
      end
    endcase
  end

  // Serial engine registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      eng_reg <= SPIEC_IDLE;
      bitCnt_reg <= 6'h00;
      txShift_reg <= {WB{1'b0}};
      rxShift_reg <= {WB{1'b0}};
      divCnt_reg <= 17'h0_0000;
      done_reg <= 3'h0;
    end else begin
      eng_reg <= eng_next;
      done_reg <= {done_reg[1:0], lastSample};
      divCnt_reg <= (~active | tick) ? 17'h0_0000 : divCnt_reg + 17'h1;
      if (load) begin
        bitCnt_reg <= 6'h00;
        txShift_reg <= loadData;
      end else begin
        if (sampleEv) begin
          bitCnt_reg <= bitCnt_reg + 6'h01;
          rxShift_reg <= {rxShift_reg[WB-2:0], inBit};
        end
        if (shiftEv) begin
          txShift_reg <= {txShift_reg[WB-2:0], 1'b0};
        end
      end
    end
  end

  // Pin drivers; fault or disable releases them
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sclkOut <= 1'b0;
      sclkOe <= 1'b0;
      mosiOe <= 1'b0;
      misoOe <= 1'b0;
      ssOutN <= 1'b1;
      ssOe <= 1'b0;
    end else begin
      sclkOut <= active & (tick ? ~sclkOut : sclkOut);
      sclkOe <= isMaster & ~mmeEv;
      mosiOe <= isMaster & ~mmeEv;
      misoOe <= selected;
      ssOutN <= ~(isMaster & active);
      ssOe <= isMaster & ~mmeEv;
    end
  end
  assign mosiOut = txShift_reg[WB-1];
  assign misoOut = txShift_reg[WB-1];

  // Port control; a fault locks out enable and master select
  always_ff @(posedge clk) begin
    if (!rstn) begin
      portEn_reg <= 1'b0;
      msSel_reg <= 1'b0;
      cph_reg <= 1'b0;
      tim_reg <= `TIM_RX;
      sz_reg <= 1'b0;
      gm_reg <= 1'b0;
      baud_reg <= `BAUD_RST;
    end else begin
      if (wrCtrl) begin
        portEn_reg <= ctrlM[`CB_EN] & ~mme_reg & ~mmeEv;
        msSel_reg <= ctrlM[`CB_MS] & ~mme_reg & ~mmeEv;
        cph_reg <= ctrlM[`CB_CPH];
        tim_reg <= ctrlM[`CB_TIM +: 2];
        sz_reg <= ctrlM[`CB_SZ];
        gm_reg <= ctrlM[`CB_GM];
      end else if (mmeEv) begin
        portEn_reg <= 1'b0;
        msSel_reg <= 1'b0;
      end
      if (wrBaud) begin
        baud_reg <= baudM[`BAUD_W-1:0];
      end
    end
  end

  // Sticky errors: a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      {transmit_collision_flag_reg, receive_overrun_flag_reg, transmit_underrun_flag_reg, mme_reg} <= 4'h0;
      {dOvf_reg, dUnf_reg, dMme_reg} <= 3'h0;
    end else begin
      mme_reg <= mmeEv | (mme_reg & ~w1c[0]);
      transmit_underrun_flag_reg <= unfEv | (transmit_underrun_flag_reg & ~w1c[1]);
      receive_overrun_flag_reg <= ovfEv | (receive_overrun_flag_reg & ~w1c[2]);
      transmit_collision_flag_reg <= colEv | (transmit_collision_flag_reg & ~w1c[3]);
      dMme_reg <= (mmeEv & dmaEn_reg) | (dMme_reg & ~w1c[0]);
      dUnf_reg <= (unfEv & dmaTxMode) | (dUnf_reg & ~w1c[1]);
      // Overrun during transmit DMA is not a DMA error
      dOvf_reg <= (ovfEv & dmaRxMode) | (dOvf_reg & ~w1c[2]);
    end
  end

  // Data buffers and their full status
  always_ff @(posedge clk) begin
    if (!rstn) begin
      txBuf_reg <= `ZERO32;
      rxBuf_reg <= `ZERO32;
      txs_reg <= 1'b0;
      rxs_reg <= 1'b0;
    end else begin
      // Full buffer is overwritten, never stalled
      if (swTxWr) begin
        txBuf_reg <= wmerge(txBuf_reg, wData_reg, wStrb_reg);
      end else if (dmaTxWe) begin
        txBuf_reg <= dmaTxData;
      end
      txs_reg <= txWrite | (txs_reg & ~load);
      // Full buffer keeps old word unless get-more is set or it is read in the same cycle
      if (rxEv & (~rxs_reg | gm_reg | rxRead)) begin
        rxBuf_reg <= rxShift_reg;
      end
      rxs_reg <= rxEv | (rxs_reg & ~rxRead);
    end
  end
  assign dmaRxData = rxBuf_reg;

  // DMA control, count and chain start
  always_ff @(posedge clk) begin
    if (!rstn) begin
      {dmaIe_reg, chEn_reg, dmaRx_reg, dmaEn_reg} <= 4'h0;
      cnt_reg <= 16'h0000;
      idx_reg <= `ZERO32;
      mod_reg <= `ZERO32;
      cp_reg <= `ZERO32;
      pSeen_reg <= 3'h0;
      dmaTxReq <= 1'b0;
      dmaRxReq <= 1'b0;
      dmaDone <= 1'b0;
      chainStart <= 1'b0;
      portIrq <= 1'b0;
    end else begin
      if (wrDmac) begin
        {dmaIe_reg, chEn_reg, dmaRx_reg, dmaEn_reg} <= dmacM[3:0];
      end
      if (wrCnt) begin
        cnt_reg <= wm[15:0];
      end else if (dmaMove) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
      if (wrIdx) begin
        idx_reg <= wmerge(idx_reg, wData_reg, wStrb_reg);
      end
      if (wrMod) begin
        mod_reg <= wmerge(mod_reg, wData_reg, wStrb_reg);
      end
      if (wrCp) begin
        cp_reg <= wmerge(cp_reg, wData_reg, wStrb_reg);
      end
      pSeen_reg <= chainStart ? 3'h0 :
          pSeen_reg | {wrCnt, wrMod, wrIdx};
      // Transmit fetch only into an empty buffer
      dmaTxReq <= dmaTxMode & portEn_reg & ~txs_reg & ~txWrite &
          (cnt_reg > 16'(dmaMove));
      dmaRxReq <= dmaRxMode & rxs_reg & ~dmaRxAck &
          (cnt_reg > 16'(dmaMove));
      dmaDone <= dmaMove & (cnt_reg == 16'h0001);
      chainStart <= wrCp & (&pSeen_reg) & dmaEn_reg & portEn_reg &
          chEn_reg;
      // Only fault and DMA errors interrupt; buffer status is polled
      portIrq <= (mme_reg & ~w1c[0]) | (dmaIe_reg & dErrs);
    end
  end

  // Bus write channel handshakes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= `ZERO32;
      wStrb_reg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OK;
    end else begin
      if (awTake) begin
        awAddr_reg <= awaddr;
      end
      if (wTake) begin
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      awHeld_reg <= awTake | (awHeld_reg & ~doWr);
      wHeld_reg <= wTake | (wHeld_reg & ~doWr);
      awready <= ~awTake & (awready | (bvalid & bready));
      wready <= ~wTake & (wready | (bvalid & bready));
      if (doWr) begin
        bvalid <= 1'b1;
        bresp <= mapped(awAddr_reg) ? `RESP_OK : `RESP_ERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read data selection
  logic [31:0] rdMux;
  always_comb begin
    rdMux = `ZERO32;
    case (araddr)
      `OFS_CTRL: rdMux = {25'h0, gm_reg, sz_reg, tim_reg, cph_reg,
          msSel_reg, portEn_reg};
      `OFS_STAT: rdMux = {25'h0, transmit_collision_flag_reg, 1'b0, receive_overrun_flag_reg, 1'b0,
          transmit_underrun_flag_reg, mme_reg, 1'b0};
      `OFS_FLAG: rdMux = {24'h0, dsS, 5'h0, txs_reg, rxs_reg};
      `OFS_BAUD: rdMux = {17'h0, baud_reg};
      `OFS_DMAC: rdMux = {16'h0, dErrs, dOvf_reg, dUnf_reg, dMme_reg,
          8'h0, dmaIe_reg, chEn_reg, dmaRx_reg, dmaEn_reg};
      `OFS_CNT: rdMux = {16'h0, cnt_reg};
      `OFS_IDX: rdMux = idx_reg;
      `OFS_MOD: rdMux = mod_reg;
      `OFS_CP: rdMux = cp_reg;
      `OFS_RX: rdMux = rxBuf_reg;
      default: rdMux = `ZERO32;
    endcase
  end

  // Bus read channel
  always_ff @(posedge clk) begin
    if (!rstn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= `ZERO32;
      rresp <= `RESP_OK;
    end else begin
      arready <= ~arTake & (arready | (rvalid & rready));
      if (arTake) begin
        rvalid <= 1'b1;
        rdata <= rdMux;
        rresp <= mapped(araddr) ? `RESP_OK : `RESP_ERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  mme_trip_a: assert property (mmeEv |=> mme_reg && !portEn_reg &&
      !msSel_reg ##1 portIrq) else $error("fault not taken");
  mme_lock_a: assert property (mme_reg |=> !portEn_reg && !msSel_reg)
      else $error("enable set during fault");
  irq_drop_a: assert property ($fell(mme_reg) && !dmaIe_reg |->
      !portIrq) else $error("fault irq kept");
  ds_flag_a: assert property (arTake && araddr == `OFS_FLAG |=>
      rdata[`FB_DS] == $past(dsS)) else $error("select bit wrong");
  pins_off_a: assert property (!portEn_reg |=> !sclkOe &&
      !mosiOe && !ssOe) else $error("driver left on");
  unf_set_a: assert property (unfEv |=> transmit_underrun_flag_reg)
    else $error("underrun lost");
  ovf_hold_a: assert property (ovfEv && !gm_reg |=> receive_overrun_flag_reg &&
      rxBuf_reg == $past(rxBuf_reg)) else $error("overrun wrong");
  col_set_a: assert property (txWrite && load && msSel_reg |=>
      transmit_collision_flag_reg) else $error("collision lost");
  col_mute_a: assert property (!msSel_reg && !cph_reg &&
      !transmit_collision_flag_reg |=> !transmit_collision_flag_reg) else $error("phase 0 collision");
  tx_stall_a: assert property (isMaster && !active && !dmaEn_reg &&
      tim_reg == `TIM_TX && !txs_reg |=> !active)
    else $error("clock ran on empty");
  rxs_lat_a: assert property (lastSample && isMaster |->
      ##4 rxs_reg) else $error("receive full late");
endmodule : spiec_top
